// ---- hdl/overcurrent_fault_response.v ----
// Notes on behaviour
// (RULE_01) On overcurrent set none-of-above, IOUT_OC, IOUT word bit and IOUT overcurrent bit.
// (RULE_02) Overcurrent drives the alert line unless that page's alert is masked.
// (RULE_03) Status bit and alert happen for every programmed response value.
// (RULE_04) Response configuration is exactly one data byte; other lengths are refused.
// (RULE_05) Response 00 keeps running in current limit forever; response 01 is unsupported.
// (RULE_06) Response 10 limits for the delay, then shuts down and follows the retry field if still limiting.
// (RULE_07) Response 11 disables the output at once, then follows the retry field.
// (RULE_08) Retry 000 never restarts; output stays off until run is cycled.
// (RULE_09) Retry 111 restarts without limit until commanded off or other fault.
// (RULE_10) Restart attempts are spaced by the restart interval setting.
// (RULE_11) Delay field counts 16 ms units of continued operation after detection.
// (RULE_12) Delay field is used only by the delayed shutdown response.
// (RULE_13) Latched fault clears on clear, off-then-on, restore, vendor reset, power cycle.
// (RULE_14) Read-only unpaged internal overtemperature response byte at 0xD6 reads 0xC0.
// (RULE_15) Response byte at 0x47 is paged, read-write, reset value 0x00.
// (RULE_16) Writing response 01 raises a communication/logic fault, not stored.
// (RULE_17) Delay count starts at detection and is abandoned if limiting ends early.
`timescale 1ns/10ps
`include "oc_fault_consts.vh"
module overcurrent_fault_response #(
    parameter integer TICK_CYCLES = `OCF_UNIT_NS / `OCF_CLK_NS
) (
    input  wire        clock,             // core clock, 250 MHz
    input  wire        nrst,              // asynchronous reset, active low
    input  wire        cmd_wr,            // write command strobe
    input  wire        cmd_rd,            // read command strobe
    input  wire [7:0]  cmd_code,          // command code
    input  wire [1:0]  wr_bytes,          // data bytes carried by the write
    input  wire [7:0]  wr_data,           // write data byte
    input  wire        page,              // selected output page
    output reg  [15:0] rd_data_q,         // read data, bytes in the low lane
    output reg         rd_valid_q,        // read data valid pulse
    input  wire [1:0]  run_pin,           // run pins, asynchronous
    input  wire [1:0]  operation_on,      // operation command on, per page
    input  wire [1:0]  oc_detect,         // overcurrent comparator, asynchronous
    input  wire [1:0]  other_fault_off,   // non-retry fault shutdown request
    input  wire [1:0]  alert_mask,        // alert mask for overcurrent, per page
    input  wire [7:0]  restart_interval,  // restart interval in delay units
    output wire [1:0]  output_enable,     // output allowed to switch, per page
    output wire [1:0]  oc_fault,          // latched overcurrent fault, per page
    output reg         cml_fault_q,       // communication/logic fault latch
    output wire        alert_out,         // alert pin output value
    output wire        alert_oe_n         // alert pin output enable, active low
);
    ////////////////////////////////////////////////////////////////////////////
    localparam [4:0] ST_OFF   = 5'h01;
    localparam [4:0] ST_ON    = 5'h02;
    localparam [4:0] ST_LIMIT = 5'h04;
    localparam [4:0] ST_WAIT  = 5'h08;
    localparam [4:0] ST_LATCH = 5'h10;

    wire       tick;
    wire [1:0] run_s;
    wire [1:0] oc_s;
    reg  [7:0] resp_q [0:1];
    reg  [1:0] fault_q;
    reg  [1:0] on_prev_q;
    reg  [1:0] out_en;

    wire       wr_resp;
    wire       wr_ok;
    wire       wr_bad;
    wire       clr_all;
    wire       restore;
    wire [1:0] new_resp;

    unit_tick #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_tick (
        .clock (clock),
        .nrst  (nrst),
        .tick  (tick)
    );

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_sync
            sync_two_flop u_run (
                .clock (clock),
                .nrst  (nrst),
                .din   (run_pin[g]),
                .dout  (run_s[g])
            );
            sync_two_flop u_oc (
                .clock (clock),
                .nrst  (nrst),
                .din   (oc_detect[g]),
                .dout  (oc_s[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Command decode.
    assign new_resp = wr_data[`OCF_RESP_HI:`OCF_RESP_LO];
    assign wr_resp  = cmd_wr & (cmd_code == `OCF_CMD_OC_RESPONSE);
    assign wr_ok    = wr_resp & (wr_bytes == `OCF_ONE_BYTE) & (new_resp != `OCF_RESP_BAD);  // [RULE_04] [RULE_16]
    assign wr_bad   = (wr_resp & ~wr_ok)
                    | (cmd_wr & (cmd_code == `OCF_CMD_OT_RESPONSE));                           // [RULE_14]
    assign clr_all  = cmd_wr & (cmd_code == `OCF_CMD_CLEAR_FAULTS);
    assign restore  = cmd_wr & ((cmd_code == `OCF_CMD_RESTORE_ALL) | (cmd_code == `OCF_CMD_VENDOR_RESET));

    // Response byte storage, one per page; restore brings back the default.
    integer i;
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            for (i = 0; i < 2; i = i + 1) begin
                resp_q[i] <= `OCF_OC_RESP_RESET;                                              // [RULE_15]
            end
        end else if (restore) begin
            for (i = 0; i < 2; i = i + 1) begin
                resp_q[i] <= `OCF_OC_RESP_RESET;
            end
        end else if (wr_ok) begin
            resp_q[page] <= wr_data;                                                          // [RULE_15]
        end
    end

    // Refused writes latch a communication/logic fault; a new one wins over clear.
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cml_fault_q <= 1'b0;
        end else if (wr_bad) begin
            cml_fault_q <= 1'b1;                                                              // [RULE_16]
        end else if (clr_all | restore) begin
            cml_fault_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Per-page fault response state machines.
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_chan
            reg  [4:0] st_q;
            reg  [7:0] cnt_q;
            wire       on_cmd;
            wire [1:0] resp;
            wire [2:0] retry;
            wire [7:0] delay;
            wire [7:0] gap;
            wire [7:0] cnt_next;
            wire       shut_next;

            assign on_cmd   = run_s[g] & operation_on[g];
            assign resp     = resp_q[g][`OCF_RESP_HI:`OCF_RESP_LO];
            assign retry    = resp_q[g][`OCF_RETRY_HI:`OCF_RETRY_LO];
            assign delay    = {5'h00, resp_q[g][`OCF_DELAY_HI:`OCF_DELAY_LO]};               // [RULE_11]
            assign gap      = (restart_interval == 8'h00) ? 8'h01 : restart_interval;
            assign cnt_next = cnt_q + 8'h01;
            assign shut_next = (retry == `OCF_RETRY_NEVER);

            always @(posedge clock or negedge nrst) begin
                if (!nrst) begin
                    st_q  <= ST_OFF;
                    cnt_q <= 8'h00;
                end else begin
                    case (st_q)
                        ST_OFF: begin
                            cnt_q <= 8'h00;
                            if (on_cmd) begin
                                st_q <= ST_ON;
                            end
                        end
                        ST_ON: begin
                            cnt_q <= 8'h00;
                            if (!on_cmd) begin
                                st_q <= ST_OFF;
                            end else if (other_fault_off[g]) begin
                                st_q <= ST_LATCH;
                            end else if (oc_s[g]) begin
                                case (resp)
                                    `OCF_RESP_DELAYED: begin
                                        if (delay == 8'h00) begin
                                            st_q <= shut_next ? ST_LATCH : ST_WAIT;           // [RULE_06]
                                        end else begin
                                            st_q <= ST_LIMIT;                                 // [RULE_17]
                                        end
                                    end
                                    `OCF_RESP_IMMEDIATE: begin
                                        st_q <= shut_next ? ST_LATCH : ST_WAIT;               // [RULE_07]
                                    end
                                    default: begin
                                        st_q <= ST_ON;                                        // [RULE_05] [RULE_12]
                                    end
                                endcase
                            end
                        end
                        ST_LIMIT: begin
                            if (!on_cmd) begin
                                st_q <= ST_OFF;
                            end else if (other_fault_off[g]) begin
                                st_q <= ST_LATCH;
                            end else if (!oc_s[g]) begin
                                st_q <= ST_ON;                                                // [RULE_17]
                            end else if (tick) begin
                                if (cnt_next >= delay) begin
                                    cnt_q <= 8'h00;
                                    st_q  <= shut_next ? ST_LATCH : ST_WAIT;                  // [RULE_06] [RULE_11]
                                end else begin
                                    cnt_q <= cnt_next;
                                end
                            end
                        end
                        ST_WAIT: begin
                            if (!on_cmd) begin
                                st_q <= ST_OFF;                                               // [RULE_09]
                            end else if (other_fault_off[g]) begin
                                st_q <= ST_LATCH;                                             // [RULE_09]
                            end else if (tick) begin
                                if (cnt_next >= gap) begin
                                    cnt_q <= 8'h00;
                                    st_q  <= ST_ON;                                           // [RULE_09] [RULE_10]
                                end else begin
                                    cnt_q <= cnt_next;
                                end
                            end
                        end
                        ST_LATCH: begin
                            cnt_q <= 8'h00;
                            if (!on_cmd) begin
                                st_q <= ST_OFF;                                               // [RULE_08]
                            end
                        end
                        default: begin
                            st_q  <= ST_OFF;
                            cnt_q <= 8'h00;
                        end
                    endcase
                end
            end

            always @* begin
                out_en[g] = (st_q == ST_ON) | (st_q == ST_LIMIT);
            end

            // Fault latch: detection while on sets it, and a set wins over any clear.
            always @(posedge clock or negedge nrst) begin
                if (!nrst) begin
                    fault_q[g]   <= 1'b0;
                    on_prev_q[g] <= 1'b0;
                end else begin
                    on_prev_q[g] <= on_cmd;
                    if (oc_s[g] & out_en[g]) begin
                        fault_q[g] <= 1'b1;                                                   // [RULE_01] [RULE_03]
                    end else if (clr_all | restore | (on_cmd & ~on_prev_q[g])) begin
                        fault_q[g] <= 1'b0;                                                   // [RULE_13]
                    end
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Status views and read port.
    function [7:0] status_byte;
        input flt;
        input cml;
        begin
            status_byte = 8'h00;
            status_byte[`OCF_SB_NONE_ABOVE] = flt | cml;                                      // [RULE_01]
            status_byte[`OCF_SB_CML]        = cml;
            status_byte[`OCF_SB_IOUT_OC]    = flt;                                            // [RULE_01]
        end
    endfunction

    reg [15:0] rd_mux;
    reg [15:0] word_v;
    reg        flt_p;

    always @* begin
        flt_p  = fault_q[page];
        word_v = {8'h00, status_byte(flt_p, cml_fault_q)};
        word_v[`OCF_SW_IOUT] = flt_p;                                                         // [RULE_01]
        case (cmd_code)
            `OCF_CMD_OC_RESPONSE: rd_mux = {8'h00, resp_q[page]};                             // [RULE_15]
            `OCF_CMD_OT_RESPONSE: rd_mux = {8'h00, `OCF_OT_RESP_VALUE};                       // [RULE_14]
            `OCF_CMD_STATUS_BYTE: rd_mux = {8'h00, status_byte(flt_p, cml_fault_q)};
            `OCF_CMD_STATUS_WORD: rd_mux = word_v;
            `OCF_CMD_STATUS_IOUT: rd_mux = {8'h00, flt_p, 7'h00};                             // [RULE_01]
            default:              rd_mux = 16'h0000;
        endcase
    end

    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rd_data_q  <= 16'h0000;
            rd_valid_q <= 1'b0;
        end else begin
            rd_valid_q <= cmd_rd;
            if (cmd_rd) begin
                rd_data_q <= rd_mux;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Open-drain alert: pulled low while any unmasked fault stands.
    assign alert_out     = 1'b0;
    assign alert_oe_n    = ~(|(fault_q & ~alert_mask) | cml_fault_q);                          // [RULE_02] [RULE_03]
    assign output_enable = out_en;
    assign oc_fault      = fault_q;
endmodule

// ---- hdl/sync_two_flop.v ----
`timescale 1ns/10ps
// Two-flop synchroniser for levels entering from outside the clock domain.
module sync_two_flop (
    input  wire clock,   // core clock
    input  wire nrst,    // asynchronous reset, active low
    input  wire din,     // asynchronous level
    output wire dout     // synchronised level
);
    reg meta_q;
    reg sync_q;

    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= din;
            sync_q <= meta_q;
        end
    end

    assign dout = sync_q;
endmodule

// ---- hdl/unit_tick.v ----
`timescale 1ns/10ps
`include "oc_fault_consts.vh"
// Free-running divider giving one pulse per delay unit.
module unit_tick #(
    parameter integer TICK_CYCLES = `OCF_UNIT_NS / `OCF_CLK_NS
) (
    input  wire clock,   // core clock
    input  wire nrst,    // asynchronous reset, active low
    output wire tick     // one-cycle pulse each unit
);
    reg [31:0] cnt_q;
    wire       wrap;

    assign wrap = (cnt_q == TICK_CYCLES - 1);

    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= 32'h00000000;
        end else if (wrap) begin
            cnt_q <= 32'h00000000;
        end else begin
            cnt_q <= cnt_q + 32'h00000001;
        end
    end

    assign tick = wrap;
endmodule

// ---- shared/oc_fault_consts.vh ----
`ifndef OC_FAULT_CONSTS_VH
`define OC_FAULT_CONSTS_VH

// Command codes seen on the command port.
`define OCF_CMD_CLEAR_FAULTS   8'h03
`define OCF_CMD_RESTORE_ALL    8'h16
`define OCF_CMD_OC_RESPONSE    8'h47
`define OCF_CMD_STATUS_BYTE    8'h78
`define OCF_CMD_STATUS_WORD    8'h79
`define OCF_CMD_STATUS_IOUT    8'h7B
`define OCF_CMD_OT_RESPONSE    8'hD6
`define OCF_CMD_VENDOR_RESET   8'hFD

// Reset and fixed values.
`define OCF_OC_RESP_RESET      8'h00
`define OCF_OT_RESP_VALUE      8'hC0

// Field positions of the overcurrent response byte.
`define OCF_RESP_HI            7
`define OCF_RESP_LO            6
`define OCF_RETRY_HI           5
`define OCF_RETRY_LO           3
`define OCF_DELAY_HI           2
`define OCF_DELAY_LO           0

// Response field codes.
`define OCF_RESP_LIMIT         2'h0
`define OCF_RESP_BAD           2'h1
`define OCF_RESP_DELAYED       2'h2
`define OCF_RESP_IMMEDIATE     2'h3
`define OCF_RETRY_NEVER        3'h0

// Status bit positions.
`define OCF_SB_NONE_ABOVE      0
`define OCF_SB_CML             1
`define OCF_SB_IOUT_OC         4
`define OCF_SW_IOUT            14
`define OCF_SI_OC_FAULT        7

// Byte count of a one-byte write.
`define OCF_ONE_BYTE           2'h1

// Timebase: 16 ms delay unit at a 4 ns clock.
`define OCF_UNIT_NS            16000000
`define OCF_CLK_NS             4

`endif

// ---- verification/overcurrent_fault_response_properties.sv ----
`timescale 1ns/10ps
module ocf_checker #(
    parameter integer TICK_CYCLES = 16
) (
    input wire        clock,            // core clock
    input wire        nrst,             // reset, active low
    input wire        cmd_wr,           // write strobe
    input wire        cmd_rd,           // read strobe
    input wire [7:0]  cmd_code,         // command code
    input wire [1:0]  wr_bytes,         // byte count
    input wire [7:0]  wr_data,          // write byte
    input wire        page,             // page
    input wire [15:0] rd_data_q,        // read data
    input wire        rd_valid_q,       // read valid
    input wire [1:0]  run_pin,          // run pins
    input wire [1:0]  operation_on,     // operation on
    input wire [1:0]  oc_detect,        // overcurrent
    input wire [1:0]  other_fault_off,  // other fault
    input wire [1:0]  alert_mask,       // alert mask
    input wire [7:0]  restart_interval, // retry spacing
    input wire [1:0]  output_enable,    // output on
    input wire [1:0]  oc_fault,         // fault latch
    input wire        cml_fault_q,      // logic fault
    input wire        alert_out,        // alert value
    input wire        alert_oe_n        // alert enable
);
    // Shadow of the page 0 response byte, kept from accepted writes.
    reg  [7:0] resp0_q;
    wire       clr_cmd = cmd_wr && (cmd_code == 8'h03 || cmd_code == 8'h16 || cmd_code == 8'hFD);
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            resp0_q <= 8'h00;
        end else if (cmd_wr && !page && cmd_code == 8'h47 && wr_bytes == 2'h1 && wr_data[7:6] != 2'h1) begin
            resp0_q <= wr_data;
        end else if (cmd_wr && (cmd_code == 8'h16 || cmd_code == 8'hFD)) begin
            resp0_q <= 8'h00;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    sequence oc_held;
        (oc_detect[0] && output_enable[0]) [*3];
    endsequence
    sequence run_held;
        (run_pin[0] && operation_on[0] && !other_fault_off[0]) [*4];
    endsequence
    fault_sets_a: assert property (oc_held |-> ##[0:2] oc_fault[0]) else $error("fault not set");
    alert_follows_a: assert property (oc_fault[0] && !alert_mask[0] |-> !alert_oe_n) else $error("no alert");
    alert_value_a: assert property (alert_out == 1'b0) else $error("alert value high");
    ot_readonly_a: assert property (cmd_rd && cmd_code == 8'hD6 |=> rd_valid_q && rd_data_q == 16'h00C0)
        else $error("bad overtemp byte");
    bad_field_a: assert property (cmd_wr && cmd_code == 8'h47 && wr_data[7:6] == 2'h1 |=> cml_fault_q)
        else $error("bad field accepted");
    one_byte_a: assert property (cmd_wr && cmd_code == 8'h47 && wr_bytes != 2'h1 |=> cml_fault_q)
        else $error("bad length accepted");
    immediate_off_a: assert property ($rose(oc_fault[0]) && resp0_q[7:6] == 2'h3 |-> !output_enable[0])
        else $error("output not off");
    limit_holds_a: assert property (run_held ##0 (resp0_q[7:6] == 2'h0 && output_enable[0]) |=> output_enable[0])
        else $error("limit mode stopped");
    fault_holds_a: assert property (run_held ##0 (oc_fault[0] && !clr_cmd) |=> oc_fault[0])
        else $error("fault dropped");
    cml_holds_a: assert property (cml_fault_q && !clr_cmd |=> cml_fault_q) else $error("logic fault dropped");
endmodule
bind overcurrent_fault_response ocf_checker #(.TICK_CYCLES(TICK_CYCLES)) u_checker (.*);

// ---- verification/pmbus_host_model.sv ----
`timescale 1ns/10ps
module pmbus_host_model (
    input  wire        clock,      // core clock
    input  wire [15:0] rd_data_q,  // read data
    input  wire        rd_valid_q, // read valid
    output reg         cmd_wr,     // write strobe
    output reg         cmd_rd,     // read strobe
    output reg  [7:0]  cmd_code,   // command code
    output reg  [1:0]  wr_bytes,   // byte count
    output reg  [7:0]  wr_data,    // write byte
    output reg         page        // page select
);
    initial begin
        cmd_wr = 1'b0;
        cmd_rd = 1'b0;
        cmd_code = 8'h00;
        wr_bytes = 2'h1;
        wr_data = 8'h00;
        page = 1'b0;
    end
    // A normal host sends one data byte; other counts are only for refusal tests.
    task write(input [7:0] code, input [1:0] n, input [7:0] d, input p);
        @(posedge clock);
        cmd_wr <= 1'b1;
        cmd_code <= code;
        wr_bytes <= n;
        wr_data <= d;
        page <= p;
        @(posedge clock);
        cmd_wr <= 1'b0;
        wr_data <= ~d;
    endtask
    task read(input [7:0] code, input p, output [15:0] d);
        @(posedge clock);
        cmd_rd <= 1'b1;
        cmd_code <= code;
        page <= p;
        @(posedge clock);
        cmd_rd <= 1'b0;
        #1;
        d = rd_valid_q ? rd_data_q : 16'hDEAD;
    endtask
endmodule

// ---- verification/tb_overcurrent_fault_response.sv ----
`timescale 1ns/10ps
module tb_overcurrent_fault_response;
    localparam integer TICK = 16;
    reg         clock;
    reg         nrst;
    reg  [1:0]  run_pin, operation_on, oc_detect, other_fault_off, alert_mask;
    reg  [7:0]  restart_interval;
    wire        cmd_wr, cmd_rd, page, rd_valid_q, cml_fault_q, alert_out, alert_oe_n;
    wire [7:0]  cmd_code, wr_data;
    wire [1:0]  wr_bytes, output_enable, oc_fault;
    wire [15:0] rd_data_q;
    integer     err_count, samples_checked, n, i;
    reg  [15:0] rd;
    overcurrent_fault_response #(.TICK_CYCLES(TICK)) u_dut (.*);
    pmbus_host_model u_host (.*);
    always #2 clock = ~clock;
    ////////////////////////////////////////////////////////////////////////////////
    task check(input string what, input [15:0] seen, input [15:0] exp);
        samples_checked = samples_checked + 1;
        if (seen !== exp) begin
            err_count = err_count + 1;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task stop_test;
        $display("comparisons %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task wait_oe(input v, input integer lim);
        #1;
        n = 0;
        while (output_enable[0] !== v && n < lim) begin
            @(posedge clock);
            #1;
            n = n + 1;
        end
        if (output_enable[0] !== v) begin
            check("enable wait", output_enable[0], v);
            stop_test;
        end
    endtask
    task refuse(input [1:0] nb, input [7:0] d);
        u_host.write(8'h47, nb, d, 1'b0);
        #1;
        check("logic fault", cml_fault_q, 1'b1);
        u_host.read(8'h47, 1'b0, rd);
        check("refused byte", rd, 16'h0000);
        u_host.write(8'h03, 2'h1, 8'h00, 1'b0);
    endtask
    task cycle_run;
        @(posedge clock) run_pin[0] <= 1'b0;
        repeat (6) @(posedge clock);
        run_pin[0] <= 1'b1;
        wait_oe(1'b1, 10);
    endtask
    task oc_pulse(input integer k);
        @(posedge clock) oc_detect[0] <= 1'b1;
        repeat (k) @(posedge clock);
        oc_detect[0] <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        nrst = 1'b0;
        run_pin = 2'b11;
        operation_on = 2'b11;
        oc_detect = 2'b00;
        other_fault_off = 2'b00;
        alert_mask = 2'b00;
        restart_interval = 8'h02;
        err_count = 0;
        samples_checked = 0;
        repeat (6) @(posedge clock);
        nrst <= 1'b1;
        u_host.read(8'h47, 1'b0, rd);
        check("response reset", rd, 16'h0000);
        u_host.write(8'hD6, 2'h1, 8'h00, 1'b0);
        #1;
        check("ot write fault", cml_fault_q, 1'b1);
        u_host.read(8'hD6, 1'b1, rd);
        check("ot byte", rd, 16'h00C0);
        u_host.write(8'h03, 2'h1, 8'h00, 1'b0);
        refuse(2'h1, 8'h40);
        refuse(2'h2, 8'hC0);
        refuse(2'h0, 8'hC0);
        wait_oe(1'b1, 10);
        $display("test registers done");
        oc_pulse(100);
        #1;
        check("limit keeps on", output_enable[0], 1'b1);
        check("fault latched", oc_fault[0], 1'b1);
        check("alert driven", alert_oe_n, 1'b0);
        check("other page", {oc_fault[1], output_enable[1]}, 2'b01);
        u_host.read(8'h78, 1'b0, rd);
        check("status byte", rd & 16'h0013, 16'h0011);
        u_host.read(8'h79, 1'b0, rd);
        check("status word", rd[14], 1'b1);
        u_host.read(8'h7B, 1'b0, rd);
        check("status iout", rd[7], 1'b1);
        @(posedge clock) alert_mask <= 2'b01;
        #1;
        check("alert masked", alert_oe_n, 1'b1);
        @(posedge clock) alert_mask <= 2'b00;
        repeat (10) @(posedge clock);
        check("fault stays", oc_fault[0], 1'b1);
        u_host.write(8'h03, 2'h1, 8'h00, 1'b0);
        #1;
        check("fault cleared", oc_fault[0], 1'b0);
        $display("test limit done");
        u_host.write(8'h47, 2'h1, 8'hC7, 1'b0);
        oc_pulse(3);
        wait_oe(1'b0, 5);
        repeat (12 * TICK) @(posedge clock);
        check("no restart", output_enable[0], 1'b0);
        cycle_run;
        check("run cycle clears", oc_fault[0], 1'b0);
        $display("test latch off done");
        u_host.write(8'h47, 2'h1, 8'hFB, 1'b0);
        for (i = 0; i < 2; i = i + 1) begin
            oc_pulse(3);
            wait_oe(1'b0, 5);
            wait_oe(1'b1, 3 * TICK + 8);
            check("retry spacing", n >= TICK, 1'b1);
        end
        @(posedge clock) other_fault_off[0] <= 1'b1;
        wait_oe(1'b0, 6);
        @(posedge clock) other_fault_off[0] <= 1'b0;
        repeat (4 * TICK) @(posedge clock);
        check("other fault stops", output_enable[0], 1'b0);
        cycle_run;
        u_host.write(8'h16, 2'h1, 8'h00, 1'b0);
        u_host.read(8'h47, 1'b0, rd);
        check("restore default", rd, 16'h0000);
        $display("test retry done");
        u_host.write(8'h47, 2'h1, 8'h83, 1'b0);
        @(posedge clock) oc_detect[0] <= 1'b1;
        wait_oe(1'b0, 3 * TICK + 8);
        check("delay length", n >= 2 * TICK, 1'b1);
        @(posedge clock) oc_detect[0] <= 1'b0;
        repeat (4 * TICK) @(posedge clock);
        check("delayed latch", output_enable[0], 1'b0);
        u_host.read(8'h47, 1'b1, rd);
        check("page apart", rd, 16'h0000);
        cycle_run;
        oc_pulse(20);
        repeat (5 * TICK) @(posedge clock);
        check("short limit kept", output_enable[0], 1'b1);
        u_host.write(8'hFD, 2'h1, 8'h00, 1'b0);
        #1;
        check("vendor reset", oc_fault[0], 1'b0);
        $display("test delayed done");
        stop_test;
    end
endmodule
